// *** core/fpr_defines.svh ***
// Purpose: register map, field layout, reset values and table codes
// Assumes: byte address = register index times four on the bus
// Notes:   figures feed fpr_range_pwm_rate_select and its helpers
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH

// register indices (byte address is index * 4)
`define FPR_IDX_REM1      8'h5F
`define FPR_IDX_LOCAL     8'h60
`define FPR_IDX_REM2      8'h61
`define FPR_IDX_CTRL      8'h62
`define FPR_IDX_STATUS    8'h63
`define FPR_IDX_MASK      8'h64
`define FPR_IDX_STATE     8'h65

// reset values
`define FPR_CFG_RESET     8'hC4
`define FPR_CTRL_RESET    2'h0
`define FPR_IRQ_RESET     4'h0

// control register fields
`define FPR_CTRL_LOCK     0
`define FPR_CTRL_PINFN    1

// interrupt status fields: bits 2:0 channel asserts pin, bit 3 hot sensed
`define FPR_IRQ_HOT       3

// behaviour codes that pick one temperature channel
`define FPR_MODE_AUTO_MAX 3'h2

// monitoring-cycle ends to wait after an assertion
`define FPR_HOLD_CYCLES   2'h2

`endif

// *** core/fpr_pkg.sv ***
// Purpose: shared types for the span/rate configuration block
// Assumes: three channels, 8-bit configuration registers
// Notes:   constants live in fpr_defines.svh
package fpr_pkg;

  // one configuration register, msb first
  typedef struct packed {
    logic [3:0] temperature_span;
    logic       thermal_output_enable;
    logic [2:0] pwm_rate_select;
  } fpr_cfg_t;

  // decoded settings for one pwm output
  typedef struct packed {
    logic [9:0]  rate_dhz;
    logic [13:0] span_chz;
    logic        span_valid;
  } fpr_pwm_t;

  // bus handshake phase
  typedef enum logic [0:0] {
    FPR_BUS_IDLE = 1'b0,
    FPR_BUS_DONE = 1'b1
  } fpr_bus_t;

endpackage

// *** core/fpr_sync.sv ***
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs are asynchronous to clk_in
// Notes:   the first stage is read only by the second
`timescale 1ns/1ps
module fpr_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,     // system clock
  input  wire logic             resetn_in,  // async reset, low
  input  wire logic [WIDTH-1:0] async_in,   // raw pin levels
  output logic      [WIDTH-1:0] sync_out    // synchronised levels
);

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // reset to idle-high so an open pin reads released
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end
        else
        begin
          meta_reg <= async_in[b];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[b] = sync_reg;
    end
  endgenerate

endmodule // fpr_sync

// *** core/fpr_thermal_alert_pin_chan.sv ***
// Purpose: per-channel thermal pin assertion with minimum hold
// Assumes: limit and release flags come from same-clock limit logic
// Notes:   hold counts monitoring-cycle ends after assertion
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_thermal_alert_pin_chan
(
  input  wire logic clk_in,         // system clock
  input  wire logic resetn_in,      // async reset, low
  input  wire logic enable_in,      // channel may drive the pin
  input  wire logic over_limit_in,  // temperature above limit
  input  wire logic at_release_in,  // temperature at release level
  input  wire logic cycle_end_in,   // end of a monitoring cycle
  output logic      asserted_out,   // channel holds pin low
  output logic      rise_out        // one-cycle assertion pulse
);

  logic       asserted_reg;
  logic [1:0] hold_reg;
  logic       start;

  assign start = !asserted_reg && enable_in && over_limit_in; // RULE6

  // two cycle ends guarantee one whole cycle after a mid-cycle start
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      asserted_reg <= 1'b0;
      hold_reg     <= 2'h0;
    end
    else if (start)
    begin
      asserted_reg <= 1'b1;
      hold_reg     <= `FPR_HOLD_CYCLES; // RULE7
    end
    else if (asserted_reg)
    begin
      if (hold_reg != 2'h0)
      begin
        if (cycle_end_in)
          hold_reg <= hold_reg - 2'h1; // RULE7
      end
      else if (at_release_in)
        asserted_reg <= 1'b0; // RULE11
    end
  end

  assign asserted_out = asserted_reg;
  assign rise_out     = start;

endmodule // fpr_thermal_alert_pin_chan

// *** core/fpr_range_pwm_rate_select.sv ***
// Purpose: span/rate configuration registers for three fan channels
// Assumes: Avalon-MM slave, byte addressing, one wait state
// Notes:   pwm waveform, limits and measurement live elsewhere
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "fpr_defines.svh"

// Behaviour
// RULE1 - lock bit makes config registers read-only
// RULE2 - remote1_span_pwm1_pwm_rate_select/local_span_pwm2_pwm_rate_select/remote2_span_pwm3_pwm_rate_select map remote1, local, remote2
// RULE3 - config registers reset to 0xC4
// RULE4 - bits 2:0 select pwm frequency
// RULE5 - rate field resets to 100, 35.3 Hz
// RULE6 - enable bit: exceed limit drives pin low
// RULE7 - pin held at least one monitoring cycle
// RULE8 - enable clear: pin is processor-hot input
// RULE9 - bits 7:4 set automatic ramp temperature span
// RULE10 - span used only under temperature-channel control
// RULE11 - release pin at external deassertion threshold
module fpr_range_pwm_rate_select
  import fpr_pkg::*;
(
  input  wire logic        clk_in,               // 100 MHz clock
  input  wire logic        resetn_in,            // async reset, low
  input  wire logic [9:0]  avs_address_in,       // byte address
  input  wire logic        avs_read_in,          // read request
  input  wire logic        avs_write_in,         // write request
  input  wire logic [3:0]  avs_byteenable_in,    // byte lanes
  input  wire logic [31:0] avs_writedata_in,     // write data
  output logic [31:0]      avs_readdata_out,     // read data
  output logic             avs_waitrequest_out,  // stall
  input  wire logic [2:0]  over_limit_in,        // temp above limit
  input  wire logic [2:0]  at_release_in,        // temp at release
  input  wire logic        cycle_end_in,         // monitor cycle end
  input  wire logic [8:0]  behaviour_select_in,  // 3 bits per pwm
  input  wire logic        thermal_alert_pin_in, // pin level
  output logic             thermal_alert_pin_out,   // pin drive value
  output logic             thermal_alert_pin_oe_out,// pin drive enable
  output logic             processor_hot_sense_out, // hot input seen
  output logic [8:0]       pwm_rate_select_out,  // 3 bits per pwm
  output logic [29:0]      pwm_rate_dhz_out,     // 0.1 Hz units
  output logic [41:0]      ramp_span_chz_out,    // 0.01 C units
  output logic [2:0]       ramp_span_valid_out,  // span in use
  output logic             irq_out               // level interrupt
);

  fpr_bus_t    bus_state_reg;
  fpr_bus_t    bus_state_next;
  fpr_cfg_t    cfg_reg [3];
  logic [1:0]  ctrl_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  index;
  logic        aligned;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic        lane0;
  logic [7:0]  wbyte;
  logic [2:0]  chan_asserted;
  logic [2:0]  chan_rise;
  logic        pin_sync;
  logic        pin_driven;
  logic        hot_level;
  logic        hot_reg;
  logic        hot_rise;
  logic [3:0]  event_set;
  logic [31:0] rd_mux;

  // request decode; the low two address bits must be zero
  assign index   = avs_address_in[9:2];
  assign aligned = (avs_address_in[1:0] == 2'h0);
  assign take    = (avs_read_in || avs_write_in) && (bus_state_reg == FPR_BUS_IDLE);
  // a write commits only at the edge where the stall is seen low
  assign wr_take = avs_write_in && aligned && (bus_state_reg == FPR_BUS_DONE);
  assign rd_take = take && avs_read_in;
  assign lane0   = avs_byteenable_in[0];
  assign wbyte   = avs_writedata_in[7:0];

  // one wait state: stall in the idle phase, answer in the done phase
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      FPR_BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
          bus_state_next = FPR_BUS_DONE;
      end
      FPR_BUS_DONE:
      begin
        bus_state_next = FPR_BUS_IDLE;
      end
      default:
      begin
        bus_state_next = FPR_BUS_IDLE;
      end
    endcase
  end

  // bus phase register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bus_state_reg <= FPR_BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in)
                               && (bus_state_reg == FPR_BUS_IDLE);

  // per-channel configuration registers; write lands in the done phase
  genvar c;
  generate
    for (c = 0; c < 3; c++)
    begin : g_cfg
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          cfg_reg[c] <= fpr_cfg_t'(`FPR_CFG_RESET); // RULE3 RULE5
        else if (wr_take && lane0
                 && (index == `FPR_IDX_REM1 + 8'(c)) // RULE2
                 && !ctrl_reg[`FPR_CTRL_LOCK]) // RULE1
          cfg_reg[c] <= fpr_cfg_t'(wbyte);
      end
    end
  endgenerate

  // control: lock is sticky until reset, so a bad write cannot undo it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ctrl_reg <= `FPR_CTRL_RESET;
    else if (wr_take && lane0 && index == `FPR_IDX_CTRL)
    begin
      ctrl_reg[`FPR_CTRL_LOCK]  <= ctrl_reg[`FPR_CTRL_LOCK]
                                   | wbyte[`FPR_CTRL_LOCK]; // RULE1
      ctrl_reg[`FPR_CTRL_PINFN] <= wbyte[`FPR_CTRL_PINFN];
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mask_reg <= `FPR_IRQ_RESET;
    else if (wr_take && lane0 && index == `FPR_IDX_MASK)
      mask_reg <= wbyte[3:0];
  end

  // sticky status, write one to clear; a same-cycle event wins
  assign event_set = {hot_rise, chan_rise};
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      status_reg <= `FPR_IRQ_RESET;
    else if (wr_take && lane0 && index == `FPR_IDX_STATUS)
      status_reg <= (status_reg & ~wbyte[3:0]) | event_set;
    else
      status_reg <= status_reg | event_set;
  end

  assign irq_out = |(status_reg & mask_reg);

  // read multiplexer; unmapped and misaligned addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (aligned)
    begin
      case (index)
        `FPR_IDX_REM1:   rd_mux = {24'h00_0000, cfg_reg[0]};
        `FPR_IDX_LOCAL:  rd_mux = {24'h00_0000, cfg_reg[1]};
        `FPR_IDX_REM2:   rd_mux = {24'h00_0000, cfg_reg[2]};
        `FPR_IDX_CTRL:   rd_mux = {30'h0000_0000, ctrl_reg};
        `FPR_IDX_STATUS: rd_mux = {28'h000_0000, status_reg};
        `FPR_IDX_MASK:   rd_mux = {28'h000_0000, mask_reg};
        `FPR_IDX_STATE:  rd_mux = {26'h000_0000, hot_reg, pin_driven,
                                   pin_sync, chan_asserted};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // read data captured in the idle phase, stands in the done phase
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_reg <= 32'h0000_0000;
    else if (rd_take)
      rdata_reg <= rd_mux;
  end

  assign avs_readdata_out = rdata_reg;

  // pin level passes two flops before any logic sees it
  fpr_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (thermal_alert_pin_in),
    .sync_out  (pin_sync)
  );

  // per-channel assertion and hold
  generate
    for (c = 0; c < 3; c++)
    begin : g_thermal_alert_pin
      fpr_thermal_alert_pin_chan u_chan (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .enable_in     (cfg_reg[c].thermal_output_enable), // RULE6
        .over_limit_in (over_limit_in[c]),
        .at_release_in (at_release_in[c]), // RULE11
        .cycle_end_in  (cycle_end_in), // RULE7
        .asserted_out  (chan_asserted[c]),
        .rise_out      (chan_rise[c])
      );
    end
  endgenerate

  // open-drain style: drive low only, release otherwise
  assign pin_driven               = |chan_asserted;
  assign thermal_alert_pin_out    = 1'b0; // RULE6
  assign thermal_alert_pin_oe_out = pin_driven; // RULE6

  // hot input only counts while no channel owns the pin as output
  assign hot_level = ctrl_reg[`FPR_CTRL_PINFN] // RULE8
                     && !(cfg_reg[0].thermal_output_enable
                          || cfg_reg[1].thermal_output_enable
                          || cfg_reg[2].thermal_output_enable) // RULE8
                     && !pin_driven && !pin_sync;

  // registered hot level; its rising edge raises a status event
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hot_reg <= 1'b0;
    else
      hot_reg <= hot_level;
  end

  assign hot_rise                = hot_level && !hot_reg;
  assign processor_hot_sense_out = hot_reg;

  // rate code to frequency in tenths of a hertz
  function automatic logic [9:0] rate_dhz(input logic [2:0] code);
    case (code)
      3'h0:    rate_dhz = 10'h06E; // RULE4
      3'h1:    rate_dhz = 10'h093;
      3'h2:    rate_dhz = 10'h0DD;
      3'h3:    rate_dhz = 10'h126;
      3'h4:    rate_dhz = 10'h161; // RULE5
      3'h5:    rate_dhz = 10'h1B9;
      3'h6:    rate_dhz = 10'h24C;
      default: rate_dhz = 10'h372;
    endcase
  endfunction

  // span code to degrees in hundredths; fractions are rounded to the nearest
  function automatic logic [13:0] span_chz(input logic [3:0] code);
    case (code)
      4'h0:    span_chz = 14'h00C8; // RULE9
      4'h1:    span_chz = 14'h00FA;
      4'h2:    span_chz = 14'h014D;
      4'h3:    span_chz = 14'h0190;
      4'h4:    span_chz = 14'h01F4;
      4'h5:    span_chz = 14'h029B;
      4'h6:    span_chz = 14'h0320;
      4'h7:    span_chz = 14'h03E8;
      4'h8:    span_chz = 14'h0535;
      4'h9:    span_chz = 14'h0640;
      4'hA:    span_chz = 14'h07D0;
      4'hB:    span_chz = 14'h0A6B;
      4'hC:    span_chz = 14'h0C80;
      4'hD:    span_chz = 14'h0FA0;
      4'hE:    span_chz = 14'h14D5;
      default: span_chz = 14'h1F40;
    endcase
  endfunction

  // per-pwm decode, registered so outputs come from flops
  generate
    for (c = 0; c < 3; c++)
    begin : g_pwm
      logic [2:0] mode;
      logic       auto_sel;
      fpr_cfg_t   src_cfg;
      fpr_pwm_t   pwm_reg;
      fpr_pwm_t   pwm_next;
      logic [2:0] rate_reg;

      assign mode     = behaviour_select_in[3*c +: 3];
      assign auto_sel = (mode <= `FPR_MODE_AUTO_MAX); // RULE10
      // span follows the temperature channel that steers this output
      always_comb
      begin
        case (mode)
          3'h0:    src_cfg = cfg_reg[0];
          3'h1:    src_cfg = cfg_reg[1]; // RULE10
          3'h2:    src_cfg = cfg_reg[2];
          default: src_cfg = cfg_reg[c];
        endcase
        pwm_next.rate_dhz   = rate_dhz(cfg_reg[c].pwm_rate_select); // RULE4
        pwm_next.span_valid = auto_sel; // RULE10
        pwm_next.span_chz   = auto_sel ? span_chz(src_cfg.temperature_span)
                                       : 14'h0000; // RULE9
      end

      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          pwm_reg  <= '0;
          rate_reg <= 3'h0;
        end
        else
        begin
          pwm_reg  <= pwm_next;
          rate_reg <= cfg_reg[c].pwm_rate_select;
        end
      end

      assign pwm_rate_select_out[3*c +: 3] = rate_reg;
      assign pwm_rate_dhz_out[10*c +: 10]  = pwm_reg.rate_dhz;
      assign ramp_span_chz_out[14*c +: 14] = pwm_reg.span_chz;
      assign ramp_span_valid_out[c]        = pwm_reg.span_valid;
    end
  endgenerate

endmodule // fpr_range_pwm_rate_select

// *** dv/fpr_range_pwm_rate_select_monitor.sv ***
// Purpose: port checker for fpr_range_pwm_rate_select
// Assumes: one clock, async low reset
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module fpr_range_pwm_rate_select_monitor
(
  input wire logic        clk_in,                   // clock
  input wire logic        resetn_in,                // reset
  input wire logic        avs_read_in,              // read
  input wire logic        avs_write_in,             // write
  input wire logic        avs_waitrequest_out,      // stall
  input wire logic [2:0]  over_limit_in,            // hot
  input wire logic [2:0]  at_release_in,            // cool
  input wire logic        cycle_end_in,             // cycle end
  input wire logic [8:0]  behaviour_select_in,      // modes
  input wire logic        thermal_alert_pin_out,    // drive
  input wire logic        thermal_alert_pin_oe_out, // enable
  input wire logic        processor_hot_sense_out,  // hot seen
  input wire logic [8:0]  pwm_rate_select_out,      // codes
  input wire logic [29:0] pwm_rate_dhz_out,         // rates
  input wire logic [41:0] ramp_span_chz_out,        // spans
  input wire logic [2:0]  ramp_span_valid_out       // in use
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // rate in 0.1 Hz for each code
  function automatic logic [9:0] rate(input logic [2:0] c);
    logic [9:0] t [8];
    t = '{10'h06e, 10'h093, 10'h0dd, 10'h126, 10'h161, 10'h1b9, 10'h24c, 10'h372};
    return t[c];
  endfunction

  logic [1:0] hold_reg;
  logic [2:0] auto_w;
  // codes 0..2 pick one temperature channel
  assign auto_w = {behaviour_select_in[8:6] <= 3'h2, behaviour_select_in[5:3] <= 3'h2,
                   behaviour_select_in[2:0] <= 3'h2};

  // cycle ends seen while driven; saturates so it never wraps
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      hold_reg <= 2'h0;
    else if (!thermal_alert_pin_oe_out)
      hold_reg <= 2'h0;
    else if (cycle_end_in && hold_reg != 2'h3)
      hold_reg <= hold_reg + 2'h1;

  a_one_wait_state:
    assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("wait state not single");
  a_pin_rise_cause:
    assert property ($rose(thermal_alert_pin_oe_out) |-> $past(over_limit_in) != 3'h0)
      else $error("pin driven without limit breach");
  a_pin_drive_low:
    assert property (thermal_alert_pin_oe_out |-> !thermal_alert_pin_out)
      else $error("pin driven high");
  a_pin_hold_min:
    assert property ($fell(thermal_alert_pin_oe_out) |-> hold_reg >= 2'h2)
      else $error("pin released before a full cycle");
  a_release_cause:
    assert property ($fell(thermal_alert_pin_oe_out) |-> $past(at_release_in) != 3'h0)
      else $error("pin released above threshold");
  a_hot_when_idle:
    assert property ($rose(processor_hot_sense_out) |-> $past(thermal_alert_pin_oe_out) == 1'b0)
      else $error("hot sensed while driving");
  a_rate_table:
    assert property ($past(resetn_in) |-> pwm_rate_dhz_out == {rate(pwm_rate_select_out[8:6]),
      rate(pwm_rate_select_out[5:3]), rate(pwm_rate_select_out[2:0])})
      else $error("rate does not match code");
  a_span_follows_mode:
    assert property ($past(resetn_in) |-> ramp_span_valid_out == $past(auto_w))
      else $error("span valid wrong for mode");
  a_span_zero_idle:
    assert property (!ramp_span_valid_out[0] |-> ramp_span_chz_out[13:0] == 14'h0000)
      else $error("span set while unused");

  c_pin_rise: cover property ($rose(thermal_alert_pin_oe_out));
  c_pin_fall: cover property ($fell(thermal_alert_pin_oe_out));
  c_hot_rise: cover property ($rose(processor_hot_sense_out));
endmodule // fpr_range_pwm_rate_select_monitor

bind fpr_range_pwm_rate_select fpr_range_pwm_rate_select_monitor u_mon (.clk_in, .resetn_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .over_limit_in, .at_release_in, .cycle_end_in,
  .behaviour_select_in, .thermal_alert_pin_out, .thermal_alert_pin_oe_out,
  .processor_hot_sense_out, .pwm_rate_select_out, .pwm_rate_dhz_out, .ramp_span_chz_out,
  .ramp_span_valid_out);

// *** dv/fpr_fan_model.sv ***
// Purpose: fan bank and thermal pin wire on the board
// Assumes: pin is open drain with a pull-up
// Notes:   hot_pull_in stands for a processor holding the pin low
`timescale 1ns/1ps
module fpr_fan_model
(
  input  wire logic [29:0] rate_dhz_in, // fan drive rates
  input  wire logic        pin_oe_in,   // block drives pin
  input  wire logic        pin_val_in,  // block drive value
  input  wire logic        hot_pull_in, // processor pulls low
  output logic             pin_out,     // wire level
  output logic             rate_ok_out  // all rates legal
);
  // pull-up wins unless someone drives low
  assign pin_out = !((pin_oe_in && !pin_val_in) || hot_pull_in);

  // fans only run at the eight listed rates
  always_comb
  begin
    rate_ok_out = 1'b1;
    for (int i = 0; i < 3; i++)
      if (!(rate_dhz_in[i*10+:10] inside {10'h06e, 10'h093, 10'h0dd, 10'h126,
            10'h161, 10'h1b9, 10'h24c, 10'h372}))
        rate_ok_out = 1'b0;
  end
endmodule // fpr_fan_model

// *** dv/fpr_range_pwm_rate_select_tb.sv ***
// Purpose: self-checking bench for fpr_range_pwm_rate_select
// Assumes: one wait state bus, fans and pin in fpr_fan_model
// Notes:   scenarios run in order; later ones rely on earlier writes
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_range_pwm_rate_select_tb;
  logic        clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic        cycle_end_in = 0, hot = 0, thermal_alert_pin_in, rate_ok, irq_out;
  logic        avs_waitrequest_out, thermal_alert_pin_out, thermal_alert_pin_oe_out;
  logic        processor_hot_sense_out;
  logic [9:0]  avs_address_in = '0;
  logic [3:0]  avs_byteenable_in = 4'h1;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
  logic [2:0]  over_limit_in = '0, at_release_in = '0, ramp_span_valid_out;
  logic [8:0]  behaviour_select_in = '0, pwm_rate_select_out;
  logic [29:0] pwm_rate_dhz_out;
  logic [41:0] ramp_span_chz_out;
  int          n_mismatch = 0, total_checks = 0;
  // rates in 0.1 Hz, spans in 0.01 C
  logic [9:0]  rt [8] = '{10'h06e, 10'h093, 10'h0dd, 10'h126, 10'h161, 10'h1b9, 10'h24c,
                          10'h372};
  logic [13:0] st [7] = '{14'h00c8, 14'h00fa, 14'h014d, 14'h0190, 14'h01f4, 14'h029b,
                          14'h0320};

  always #5 clk_in = !clk_in;

  fpr_range_pwm_rate_select dut (.clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .over_limit_in, .at_release_in, .cycle_end_in, .behaviour_select_in,
    .thermal_alert_pin_in, .thermal_alert_pin_out, .thermal_alert_pin_oe_out,
    .processor_hot_sense_out, .pwm_rate_select_out, .pwm_rate_dhz_out,
    .ramp_span_chz_out, .ramp_span_valid_out, .irq_out);

  fpr_fan_model fans (.rate_dhz_in(pwm_rate_dhz_out), .pin_oe_in(thermal_alert_pin_oe_out),
    .pin_val_in(thermal_alert_pin_out), .hot_pull_in(hot), .pin_out(thermal_alert_pin_in),
    .rate_ok_out(rate_ok));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one access held until the stall is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= {idx, 2'h0};
    avs_writedata_in <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (avs_waitrequest_out !== 1'b0 && i < 20);
    if (i >= 20)
    begin
      n_mismatch++;
      test_done();
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask

  // bounded wait on pin enable (sel 0) or hot sense (sel 1)
  task automatic wait_on(input logic sel, input logic v);
    int i;
    i = 0;
    while ((sel ? processor_hot_sense_out : thermal_alert_pin_oe_out) !== v && i < 40)
    begin
      @(negedge clk_in);
      i++;
    end
    if (i >= 40)
    begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic pulse();
    @(posedge clk_in);
    cycle_end_in <= 1'b1;
    @(posedge clk_in);
    cycle_end_in <= 1'b0;
  endtask

  task automatic t_reset();
    rdchk("cfg remote1", `FPR_IDX_REM1, `FPR_CFG_RESET);
    rdchk("cfg local", `FPR_IDX_LOCAL, `FPR_CFG_RESET);
    rdchk("cfg remote2", `FPR_IDX_REM2, `FPR_CFG_RESET);
    chk("reset rates", {rt[4], rt[4], rt[4]}, pwm_rate_dhz_out);
    rdchk("unmapped", 8'h70, 8'h00);
  endtask

  // every code on pwm1, then other registers leave pwm1 alone
  task automatic t_rates();
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, `FPR_IDX_REM1, {5'h18, k[2:0]});
      repeat (2) @(negedge clk_in);
      chk("rate pwm1", rt[k], pwm_rate_dhz_out[9:0]);
    end
    bus(1'b1, `FPR_IDX_LOCAL, 8'hc7);
    bus(1'b1, `FPR_IDX_REM2, 8'hc0);
    repeat (2) @(negedge clk_in);
    chk("rates by map", {rt[0], rt[7], rt[7]}, pwm_rate_dhz_out);
    chk("fans accept", 32'h1, rate_ok);
  endtask

  task automatic t_span();
    for (int k = 0; k < 7; k++)
    begin
      bus(1'b1, `FPR_IDX_REM1, {k[3:0], 4'h4});
      repeat (2) @(negedge clk_in);
      chk("span pwm1", st[k], ramp_span_chz_out[13:0]);
    end
    @(posedge clk_in);
    behaviour_select_in <= 9'h001;
    repeat (2) @(negedge clk_in);
    chk("span from local", 32'h0c80, ramp_span_chz_out[13:0]);
    @(posedge clk_in);
    behaviour_select_in <= 9'h003;
    repeat (2) @(negedge clk_in);
    chk("span unused", 32'h0, {ramp_span_chz_out[13:0], ramp_span_valid_out[0]});
  endtask

  // breach, minimum hold, release, then interrupt mask and clear
  task automatic t_thermal_alert_pin();
    bus(1'b1, `FPR_IDX_MASK, 8'h01);
    bus(1'b1, `FPR_IDX_REM1, 8'hc8);
    @(posedge clk_in);
    over_limit_in <= 3'h1;
    wait_on(1'b0, 1'b1);
    chk("pin drive", 32'h2, {thermal_alert_pin_oe_out, thermal_alert_pin_out});
    chk("irq raised", 32'h1, irq_out);
    @(posedge clk_in);
    over_limit_in <= 3'h0;
    at_release_in <= 3'h1;
    pulse();
    repeat (3) @(negedge clk_in);
    chk("held one cycle", 32'h1, thermal_alert_pin_oe_out);
    @(posedge clk_in);
    at_release_in <= 3'h0;
    pulse();
    repeat (3) @(negedge clk_in);
    chk("held above release", 32'h1, thermal_alert_pin_oe_out);
    @(posedge clk_in);
    at_release_in <= 3'h1;
    wait_on(1'b0, 1'b0);
    rdchk("status set", `FPR_IDX_STATUS, 8'h01);
    bus(1'b1, `FPR_IDX_MASK, 8'h00);
    @(negedge clk_in);
    chk("irq masked", 32'h0, irq_out);
    bus(1'b1, `FPR_IDX_STATUS, 8'h01);
    rdchk("status clear", `FPR_IDX_STATUS, 8'h00);
    at_release_in <= 3'h0;
  endtask

  task automatic t_hot();
    bus(1'b1, `FPR_IDX_REM1, 8'hc4);
    bus(1'b1, `FPR_IDX_CTRL, 8'h02);
    @(posedge clk_in);
    hot <= 1'b1;
    wait_on(1'b1, 1'b1);
    chk("hot sensed", 32'h1, processor_hot_sense_out);
    rdchk("hot status", `FPR_IDX_STATUS, 8'h08);
    hot <= 1'b0;
  endtask

  task automatic t_lock();
    bus(1'b1, `FPR_IDX_CTRL, 8'h03);
    bus(1'b1, `FPR_IDX_REM2, 8'h17);
    rdchk("locked cfg", `FPR_IDX_REM2, 8'hc0);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_rates();
    t_span();
    t_thermal_alert_pin();
    t_hot();
    t_lock();
    test_done();
  end
endmodule // fpr_range_pwm_rate_select_tb
